// File: core/dmap_pkg.sv
// Shared constants, types and helpers for the DDR module access port
package dmap_pkg;
    // Widths of the module data path and address pins
    localparam int DMAP_DQ_W     = 64;
    localparam int DMAP_LANE_N   = 8;
    localparam int DMAP_BANK_N   = 4;
    localparam int DMAP_ADDR_W   = 13;
    localparam int DMAP_COL_W    = 6;
    localparam int DMAP_ROWU_W   = 2;
    localparam int DMAP_FIFO_D   = 4;
    // Command codes on {row strobe, column strobe, write enable}, all active low
    localparam logic [2:0] DMAP_CMD_LMR = 3'h0;
    localparam logic [2:0] DMAP_CMD_REF = 3'h1;
    localparam logic [2:0] DMAP_CMD_PRE = 3'h2;
    localparam logic [2:0] DMAP_CMD_ACT = 3'h3;
    localparam logic [2:0] DMAP_CMD_WR  = 3'h4;
    localparam logic [2:0] DMAP_CMD_RD  = 3'h5;
    // Address bit positions with a special meaning
    localparam int DMAP_AP_BIT  = 10;
    localparam int DMAP_BT_BIT  = 3;
    localparam int DMAP_BL_LSB  = 0;
    localparam logic [1:0] DMAP_MR_BANK = 2'h0;
    // Burst length codes and the lengths they select
    localparam logic [2:0] DMAP_BL2 = 3'h1;
    localparam logic [2:0] DMAP_BL4 = 3'h2;
    localparam logic [2:0] DMAP_BL8 = 3'h3;
    localparam logic [3:0] DMAP_LEN2 = 4'h2;
    localparam logic [3:0] DMAP_LEN4 = 4'h4;
    localparam logic [3:0] DMAP_LEN8 = 4'h8;
    // Read latency in link clocks
    localparam logic [1:0] DMAP_RD_LAT = 2'h2;
    // Refresh busy time
    localparam int DMAP_CLK_NS = 8;
    localparam int DMAP_REF_NS = 70;
    localparam int DMAP_REF_CYC = (DMAP_REF_NS + DMAP_CLK_NS - 1) / DMAP_CLK_NS;
    typedef enum logic [1:0] {DMAP_RD_IDLE, DMAP_RD_WAIT, DMAP_RD_BURST} dmap_rd_e;
    // Column of one beat: sequential or interleaved order, wrapping in the block
    function automatic logic [DMAP_COL_W-1:0] dmap_col_of(input logic [DMAP_COL_W-1:0] st,
                                                          input logic [2:0] idx,
                                                          input logic [3:0] len,
                                                          input logic       il);
        logic [2:0] m;
        logic [2:0] off;
        m   = 3'(len - 4'h1);
        off = il ? ((st[2:0] ^ idx) & m) : (3'(st[2:0] + idx) & m);
        return {st[DMAP_COL_W-1:3], (st[2:0] & ~m) | off};
    endfunction : dmap_col_of
endpackage : dmap_pkg

// File: core/dmap_fifo.sv
// Small valid/ready FIFO for captured write beats
`timescale 1ns/100ps
module dmap_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input  wire logic         clk_sys_in,
    input  wire logic         nrst_in,
    // Fill side
    input  wire logic         in_valid_in,
    output logic              in_ready_out,
    input  wire logic [W-1:0] in_data_in,
    // Drain side
    output logic              out_valid_out,
    input  wire logic         out_ready_in,
    output logic [W-1:0]      out_data_out
);
    localparam int PW = $clog2(DEPTH);
    logic [W-1:0]  mem [DEPTH];
    logic [PW-1:0] wp, rp, next_wp, next_rp;
    logic [PW:0]   cnt, next_cnt;
    logic          push, pop;

    // Handshakes and pointer updates
    assign in_ready_out  = cnt != (PW+1)'(DEPTH);
    assign out_valid_out = cnt != '0;
    assign out_data_out  = mem[rp];
    assign push = in_valid_in && in_ready_out;
    assign pop  = out_valid_out && out_ready_in;
    always_comb begin
        next_wp  = push ? PW'((wp + 1'b1) % DEPTH) : wp;
        next_rp  = pop ? PW'((rp + 1'b1) % DEPTH) : rp;
        next_cnt = cnt + (PW+1)'(push) - (PW+1)'(pop);
    end

    // Registers of the FIFO
    always_ff @(posedge clk_sys_in) begin
        if (!nrst_in) begin
            wp  <= '0;
            rp  <= '0;
            cnt <= '0;
        end else begin
            wp  <= next_wp;
            rp  <= next_rp;
            cnt <= next_cnt;
        end
        if (push) begin
            mem[wp] <= in_data_in;
        end
    end
endmodule : dmap_fifo

// File: core/dmap_mem.sv
// Byte-writable storage array with registered read data
`timescale 1ns/100ps
module dmap_mem #(
    parameter int LANES = 8,
    parameter int AW    = 10
) (
    // Clock
    input  wire logic                 clk_sys_in,
    // Write port
    input  wire logic                 we_in,
    input  wire logic [LANES-1:0]     be_in,
    input  wire logic [AW-1:0]        waddr_in,
    input  wire logic [LANES*8-1:0]   wdata_in,
    // Read port
    input  wire logic [AW-1:0]        raddr_in,
    output logic [LANES*8-1:0]        rdata_out
);
    // One byte array per lane, each with its own write enable and read register
    for (genvar l = 0; l < LANES; l++) begin : g_lane
        logic [7:0] lane_arr [2**AW];
        always_ff @(posedge clk_sys_in) begin
            if (we_in && be_in[l]) begin
                lane_arr[waddr_in] <= wdata_in[l*8 +: 8];
            end
            rdata_out[l*8 +: 8] <= lane_arr[raddr_in];
        end
    end
endmodule : dmap_mem

// File: core/dmap_top.sv
// Device side of the DDR module command and data port
// Operation
// RULE1: Commands registered at each link clock rise
// RULE2: Write data captured on both strobe edges
// RULE3: Read data launched at clock edges
// RULE4: Strobe driven only during data bursts
// RULE5: Read strobe edges align with data beats
// RULE6: Core word prefetched ahead of pin beats
// RULE7: Bursts follow programmed length and order
// RULE8: Controller activates row before read/write
// RULE9: Activate takes bank and row address
// RULE10: Read/write takes bank and start column
// RULE11: Burst lengths two, four or eight
// RULE12: Auto precharge closes row after burst
// RULE13: Four banks tracked independently
// RULE14: Sixty-four bit bidirectional data bus
// RULE15: Auto refresh and power-down supported
// RULE16: Deselected commands are ignored
// RULE17: Write mask blocks storing masked bytes
// RULE18: Precharge flag selects all banks
// RULE19: Controller keeps clock gate high in accesses
// RULE20: Controller precharges before opening new row
`timescale 1ns/100ps
module dmap_top
    import dmap_pkg::*;
#(
    parameter int DQ_W   = DMAP_DQ_W,
    parameter int LANE_N = DMAP_LANE_N
) (
    // Clock and reset
    input  wire logic                   clk_sys_in,
    input  wire logic                   nrst_in,
    // Link clock and command pins
    input  wire logic                   diff_clock_true_in,
    input  wire logic                   diff_clock_comp_in,
    input  wire logic                   clock_gate_in,
    input  wire logic                   sel_n_in,
    input  wire logic                   row_strobe_n_in,
    input  wire logic                   col_strobe_n_in,
    input  wire logic                   write_en_n_in,
    input  wire logic [1:0]             bank_sel_in,
    input  wire logic [DMAP_ADDR_W-1:0] addr_lines_in,
    // Data bus, mask and strobe
    input  wire logic [DQ_W-1:0]        data_lines_in,
    output logic [DQ_W-1:0]             data_lines_out,
    output logic                        data_lines_oe_out,
    input  wire logic [LANE_N-1:0]      write_byte_mask_in,
    input  wire logic [LANE_N-1:0]      data_strobe_in,
    output logic [LANE_N-1:0]           data_strobe_out,
    output logic [LANE_N-1:0]           data_strobe_oe_out,
    // Status
    output logic [DMAP_BANK_N-1:0]      bank_open_out,
    output logic                        power_down_out,
    output logic                        refresh_busy_out,
    output logic                        write_overrun_out
);
    localparam int PIN_W = 7 + 2 + DMAP_ADDR_W + DQ_W + 2 * LANE_N;
    localparam int MA_W  = 2 + DMAP_ROWU_W + DMAP_COL_W;
    localparam int FW    = LANE_N + MA_W + DQ_W;
    localparam int RC_W  = $clog2(DMAP_REF_CYC + 1);

    // Two-stage synchronisers for every pin, then one extra stage for edges
    logic [PIN_W-1:0] pin_s1, pin_s2;
    logic             true_d, dqs_d;
    always_ff @(posedge clk_sys_in) begin
        pin_s1 <= {diff_clock_true_in, diff_clock_comp_in, clock_gate_in, sel_n_in, row_strobe_n_in,
                   col_strobe_n_in, write_en_n_in, bank_sel_in, addr_lines_in, data_lines_in,
                   write_byte_mask_in, data_strobe_in};
        pin_s2 <= pin_s1;
        true_d <= pin_s2[PIN_W-1];
        dqs_d  <= pin_s2[0];
    end

    // Unpacked synchronised pins
    logic                   true_s, comp_s, cke_s, sel_n_s;
    logic [2:0]             cmd_s;
    logic [1:0]             bank_s;
    logic [DMAP_ADDR_W-1:0] addr_s;
    logic [DQ_W-1:0]        dq_s;
    logic [LANE_N-1:0]      mask_s, dqs_s;
    assign {true_s, comp_s, cke_s, sel_n_s, cmd_s, bank_s, addr_s, dq_s, mask_s, dqs_s} = pin_s2;

    // Link clock edges and the command strobe
    logic lk_rise, lk_fall, lk_edge, dqs_edge, cmd_fire;
    assign lk_rise  = true_s && !true_d && !comp_s;
    assign lk_fall  = !true_s && true_d;
    assign lk_edge  = lk_rise || lk_fall;
    assign dqs_edge = dqs_s[0] != dqs_d;
    // RULE1: command taken at rise
    // RULE16: deselect masks the command
    assign cmd_fire = lk_rise && cke_s && !sel_n_s && !power_down_out;

    // Control state
    dmap_rd_e              rd_state, next_rd_state;
    logic [1:0]            rd_cnt, next_rd_cnt, rd_bank, next_rd_bank, wr_bank, next_wr_bank;
    logic [3:0]            rd_beat, next_rd_beat, wr_beat, next_wr_beat, mode_len, next_mode_len;
    logic [DMAP_COL_W-1:0] rd_start, next_rd_start, wr_start, next_wr_start;
    logic                  rd_ap, next_rd_ap, wr_ap, next_wr_ap, wr_active, next_wr_active;
    logic                  mode_il, next_mode_il, next_pwr_dn, next_dq_oe, next_dqs, next_ovr;
    logic [DQ_W-1:0]       next_dq_out;
    logic [RC_W-1:0]       ref_cnt, next_ref_cnt;
    logic [DMAP_BANK_N-1:0]   act_v, cls_v;
    logic [DMAP_ROWU_W-1:0]   bank_row [DMAP_BANK_N];
    logic                  push, fifo_in_ready, fifo_out_valid, drain_ready;
    logic [FW-1:0]         fifo_in, fifo_out;
    logic [DQ_W-1:0]       mem_q;
    logic [MA_W-1:0]       rd_addr;
    logic                  strobe_lvl;

    // Next values of the command, read and write sequencers
    always_comb begin
        next_rd_state  = rd_state;
        next_rd_cnt    = rd_cnt;
        next_rd_beat   = rd_beat;
        next_rd_bank   = rd_bank;
        next_rd_start  = rd_start;
        next_rd_ap     = rd_ap;
        next_wr_active = wr_active;
        next_wr_beat   = wr_beat;
        next_wr_bank   = wr_bank;
        next_wr_start  = wr_start;
        next_wr_ap     = wr_ap;
        next_mode_len  = mode_len;
        next_mode_il   = mode_il;
        next_pwr_dn    = power_down_out;
        next_dq_out    = data_lines_out;
        next_dq_oe     = data_lines_oe_out;
        next_dqs       = strobe_lvl;
        next_ref_cnt   = (ref_cnt != '0) ? RC_W'(ref_cnt - 1'b1) : ref_cnt;
        next_ovr       = 1'b0;
        act_v          = '0;
        cls_v          = '0;
        push           = 1'b0;
        // RULE15: power-down entry and exit
        if (lk_rise) begin
            next_pwr_dn = !cke_s && rd_state == DMAP_RD_IDLE && !wr_active;
        end
        // RULE3: read beats launched on link edges
        // RULE5: strobe edge-aligned with each beat
        // RULE6: prefetched word presented per half clock
        unique case (rd_state)
            DMAP_RD_IDLE: begin
            end
            DMAP_RD_WAIT: begin
                if (lk_rise) begin
                    if (rd_cnt == 2'h1) begin
                        next_rd_state = DMAP_RD_BURST;
                        next_dq_out   = mem_q;
                        next_dq_oe    = 1'b1;
                        next_dqs      = 1'b1;
                        next_rd_beat  = rd_beat + 4'h1;
                    end else begin
                        next_rd_cnt = rd_cnt - 2'h1;
                    end
                end
            end
            DMAP_RD_BURST: begin
                if (lk_edge) begin
                    if (rd_beat == mode_len) begin
                        next_rd_state = DMAP_RD_IDLE;
                        next_dq_oe    = 1'b0;
                        next_dqs      = 1'b0;
                        // RULE12: auto precharge after read burst
                        cls_v[rd_bank] = rd_ap;
                    end else begin
                        next_dq_out  = mem_q;
                        next_dqs     = lk_rise;
                        next_rd_beat = rd_beat + 4'h1;
                    end
                end
            end
        endcase
        // RULE2: one beat per strobe edge, both directions
        if (wr_active && dqs_edge) begin
            push     = 1'b1;
            next_ovr = !fifo_in_ready;
            if (wr_beat == mode_len - 4'h1) begin
                next_wr_active = 1'b0;
                // RULE12: auto precharge after write burst
                if (wr_ap) begin
                    cls_v[wr_bank] = 1'b1;
                end
            end else begin
                next_wr_beat = wr_beat + 4'h1;
            end
        end
        if (cmd_fire) begin
            unique case (cmd_s)
                // RULE9: bank and row taken on activate
                DMAP_CMD_ACT: act_v[bank_s] = 1'b1;
                // RULE18: flag bit chooses one or all banks
                DMAP_CMD_PRE: begin
                    if (addr_s[DMAP_AP_BIT]) begin
                        cls_v = '1;
                    end else begin
                        cls_v[bank_s] = 1'b1;
                    end
                end
                // RULE10: bank and start column taken
                DMAP_CMD_RD: begin
                    next_rd_state = DMAP_RD_WAIT;
                    next_rd_cnt   = DMAP_RD_LAT;
                    next_rd_beat  = '0;
                    next_rd_bank  = bank_s;
                    next_rd_start = addr_s[DMAP_COL_W-1:0];
                    next_rd_ap    = addr_s[DMAP_AP_BIT];
                end
                DMAP_CMD_WR: begin
                    next_wr_active = 1'b1;
                    next_wr_beat   = '0;
                    next_wr_bank   = bank_s;
                    next_wr_start  = addr_s[DMAP_COL_W-1:0];
                    next_wr_ap     = addr_s[DMAP_AP_BIT];
                end
                // RULE15: auto refresh occupies the array
                DMAP_CMD_REF: next_ref_cnt = RC_W'(DMAP_REF_CYC);
                // RULE11: burst length programmed as 2, 4 or 8
                DMAP_CMD_LMR: begin
                    if (bank_s == DMAP_MR_BANK) begin
                        unique case (addr_s[DMAP_BL_LSB +: 3])
                            DMAP_BL2: next_mode_len = DMAP_LEN2;
                            DMAP_BL4: next_mode_len = DMAP_LEN4;
                            DMAP_BL8: next_mode_len = DMAP_LEN8;
                            default:  next_mode_len = mode_len;
                        endcase
                        next_mode_il = addr_s[DMAP_BT_BIT];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Sequencer registers
    always_ff @(posedge clk_sys_in) begin
        if (!nrst_in) begin
            rd_state <= DMAP_RD_IDLE;
            rd_cnt   <= '0;
            rd_beat  <= '0;
            rd_bank  <= '0;
            rd_start <= '0;
            rd_ap    <= 1'b0;
            wr_active <= 1'b0;
            wr_beat  <= '0;
            wr_bank  <= '0;
            wr_start <= '0;
            wr_ap    <= 1'b0;
            mode_len <= DMAP_LEN2;
            mode_il  <= 1'b0;
            power_down_out    <= 1'b0;
            data_lines_out    <= '0;
            data_lines_oe_out <= 1'b0;
            strobe_lvl        <= 1'b0;
            ref_cnt           <= '0;
            write_overrun_out <= 1'b0;
        end else begin
            rd_state <= next_rd_state;
            rd_cnt   <= next_rd_cnt;
            rd_beat  <= next_rd_beat;
            rd_bank  <= next_rd_bank;
            rd_start <= next_rd_start;
            rd_ap    <= next_rd_ap;
            wr_active <= next_wr_active;
            wr_beat  <= next_wr_beat;
            wr_bank  <= next_wr_bank;
            wr_start <= next_wr_start;
            wr_ap    <= next_wr_ap;
            mode_len <= next_mode_len;
            mode_il  <= next_mode_il;
            power_down_out    <= next_pwr_dn;
            data_lines_out    <= next_dq_out;
            data_lines_oe_out <= next_dq_oe;
            strobe_lvl        <= next_dqs;
            ref_cnt           <= next_ref_cnt;
            write_overrun_out <= next_ovr;
        end
    end

    // RULE4: strobe and data driven only in a read burst
    // RULE14: all lanes of the wide bus move together
    assign data_strobe_out    = {LANE_N{strobe_lvl}};
    assign data_strobe_oe_out = {LANE_N{data_lines_oe_out}};
    assign refresh_busy_out   = ref_cnt != '0;

    // RULE13: open state and row per bank
    for (genvar b = 0; b < DMAP_BANK_N; b++) begin : g_bank
        logic                   open_q, next_open;
        logic [DMAP_ROWU_W-1:0] row_q, next_row;
        always_comb begin
            next_open = cls_v[b] ? 1'b0 : open_q;
            next_row  = row_q;
            if (act_v[b]) begin
                next_open = 1'b1;
                next_row  = addr_s[DMAP_ROWU_W-1:0];
            end
        end
        always_ff @(posedge clk_sys_in) begin
            if (!nrst_in) begin
                open_q <= 1'b0;
                row_q  <= '0;
            end else begin
                open_q <= next_open;
                row_q  <= next_row;
            end
        end
        assign bank_open_out[b] = open_q;
        assign bank_row[b]      = row_q;
    end

    // RULE7: beat columns in programmed order
    // RULE17: mask travels with each write beat
    assign rd_addr = {rd_bank, bank_row[rd_bank], dmap_col_of(rd_start, rd_beat[2:0], mode_len, mode_il)};
    assign fifo_in = {mask_s, wr_bank, bank_row[wr_bank],
                      dmap_col_of(wr_start, wr_beat[2:0], mode_len, mode_il), dq_s};
    // Hold array writes during a read burst so read data stay coherent
    assign drain_ready = rd_state != DMAP_RD_BURST;

    // Write beat buffer
    dmap_fifo #(.W(FW), .DEPTH(DMAP_FIFO_D)) u_fifo (
        .clk_sys_in   (clk_sys_in),
        .nrst_in      (nrst_in),
        .in_valid_in  (push),
        .in_ready_out (fifo_in_ready),
        .in_data_in   (fifo_in),
        .out_valid_out(fifo_out_valid),
        .out_ready_in (drain_ready),
        .out_data_out (fifo_out)
    );

    // Storage array; masked bytes are not written
    dmap_mem #(.LANES(LANE_N), .AW(MA_W)) u_mem (
        .clk_sys_in(clk_sys_in),
        .we_in     (fifo_out_valid && drain_ready),
        .be_in     (~fifo_out[FW-1 -: LANE_N]),
        .waddr_in  (fifo_out[DQ_W +: MA_W]),
        .wdata_in  (fifo_out[DQ_W-1:0]),
        .raddr_in  (rd_addr),
        .rdata_out (mem_q)
    );

    // Checks
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!nrst_in);
    sequence s_act_cmd;
        cmd_fire && cmd_s == DMAP_CMD_ACT;
    endsequence
    sequence s_burst_end;
        $fell(data_lines_oe_out);
    endsequence
    chk_sel_masks: assert property ((lk_rise && sel_n_s) |=> !$rose(wr_active) && $stable(mode_len)) // RULE16
        else $error("deselected command took effect");
    chk_strobe_idle: assert property (data_strobe_oe_out[0] |-> rd_state == DMAP_RD_BURST) // RULE4
        else $error("strobe driven outside read burst");
    chk_read_edge: assert property ($changed(data_strobe_out[0]) |-> $past(lk_edge)) // RULE3
        else $error("read strobe moved off a link edge");
    chk_act_opens: assert property (s_act_cmd |=> bank_open_out[$past(bank_s)]) // RULE9
        else $error("activate did not open bank");
    chk_pre_all: assert property ((cmd_fire && cmd_s == DMAP_CMD_PRE && addr_s[DMAP_AP_BIT]) |=> bank_open_out == '0) // RULE18
        else $error("precharge all left a bank open");
    chk_wr_capture: assert property ((wr_active && dqs_edge) |-> push ##1 (wr_active || $past(wr_beat) == mode_len - 4'h1)) // RULE2
        else $error("write beat not captured");
    chk_mask_carry: assert property (push |-> fifo_in[FW-1 -: LANE_N] == mask_s) // RULE17
        else $error("mask lost on write beat");
    chk_burst_len: assert property (s_burst_end |-> $past(rd_beat) == mode_len) // RULE11
        else $error("read burst length wrong");
    chk_auto_pre: assert property ((rd_state == DMAP_RD_BURST && lk_edge && rd_beat == mode_len && rd_ap)
                                   |=> !bank_open_out[$past(rd_bank)]) // RULE12
        else $error("auto precharge missed");
    chk_read_lat: assert property ((cmd_fire && cmd_s == DMAP_CMD_RD) |-> ##[1:60] $rose(data_lines_oe_out)) // read burst starts within 60 clocks of a read command
        else $error("read burst did not start");
endmodule : dmap_top

// File: dv/dmap_ctrl_model.sv
// Behavioural memory controller driving the link side of the port
`timescale 1ns/100ps
module dmap_ctrl_model
    import dmap_pkg::*;
(
    // System clock
    input  wire logic                   clk_sys_in,
    // Link pins toward the port
    output logic                        ck_t_out,
    output logic                        ck_c_out,
    output logic                        gate_out,
    output logic                        sel_n_out,
    output logic [2:0]                  cmd_n_out,
    output logic [1:0]                  bank_out,
    output logic [DMAP_ADDR_W-1:0]      addr_out,
    output logic [DMAP_DQ_W-1:0]        dq_out,
    output logic [DMAP_LANE_N-1:0]      dm_out,
    output logic [DMAP_LANE_N-1:0]      dqs_out,
    // Resolved bus levels
    input  wire logic [DMAP_DQ_W-1:0]   dq_in,
    input  wire logic                   dq_oe_in,
    input  wire logic [DMAP_LANE_N-1:0] dqs_in
);
    logic [63:0] rd_q[$];
    logic        last_dqs = 1'b0;
    // free-running pair, ten system clocks per period, fixed phase offset from system clock
    initial begin
        {gate_out, sel_n_out, cmd_n_out, bank_out, addr_out} = {5'h1F, 15'h0};
        {dq_out, dm_out, dqs_out} = '0;
        ck_t_out = 1'b0;
        #13.7;
        forever #40 ck_t_out = ~ck_t_out;
    end
    assign ck_c_out = ~ck_t_out;
    // pins set mid-period, held across the rise
    task automatic cmd(input logic sel, input logic [2:0] code, input logic [1:0] ba, input logic [12:0] a);
        @(negedge ck_t_out);
        @(posedge clk_sys_in);
        sel_n_out <= ~sel;
        cmd_n_out <= code;
        bank_out <= ba;
        addr_out <= a;
        @(negedge ck_t_out);
        @(posedge clk_sys_in);
        sel_n_out <= 1'b1;
    endtask : cmd
    // strobe edge centred in each beat, quiet after
    task automatic wr(input logic [63:0] d[8], input logic [7:0] m[8], input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_sys_in);
            dq_out <= d[i];
            dm_out <= m[i];
            repeat (2) @(posedge clk_sys_in);
            dqs_out <= {8{~i[0]}};
            repeat (2) @(posedge clk_sys_in);
        end
        @(posedge clk_sys_in);
        dq_out <= ~dq_out;
    endtask : wr
    // One read beat per strobe level change while the port drives
    always @(posedge clk_sys_in) begin
        if (dq_oe_in === 1'b1 && dqs_in[0] !== last_dqs) rd_q.push_back(dq_in);
        last_dqs <= (dq_oe_in === 1'b1) ? dqs_in[0] : 1'b0;
    end
endmodule : dmap_ctrl_model

// File: dv/tb_top.sv
// Self-checking bench for the DDR module access port
`timescale 1ns/100ps
module tb_top import dmap_pkg::*;;
    logic        clk_sys_in = 1'b0;
    logic        nrst_in = 1'b0;
    logic        ck_t, ck_c, gate, sel_n, dq_oe, pd, ref_busy, ovr;
    logic [2:0]  cmd_n;
    logic [1:0]  ba;
    logic [12:0] addr;
    logic [63:0] dq_w, dq_r, dq_bus;
    logic [7:0]  dm, dqs_w, dqs_r, dqs_oe, dqs_bus;
    logic [3:0]  bank_open;
    int          mismatches = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    // Bus levels seen by both parties
    assign dq_bus = (dq_oe === 1'b1) ? dq_r : dq_w;
    assign dqs_bus = (dqs_oe[0] === 1'b1) ? dqs_r : dqs_w;
    dmap_top dut (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .diff_clock_true_in(ck_t),
        .diff_clock_comp_in(ck_c), .clock_gate_in(gate), .sel_n_in(sel_n), .row_strobe_n_in(cmd_n[2]),
        .col_strobe_n_in(cmd_n[1]), .write_en_n_in(cmd_n[0]), .bank_sel_in(ba), .addr_lines_in(addr),
        .data_lines_in(dq_bus), .data_lines_out(dq_r), .data_lines_oe_out(dq_oe), .write_byte_mask_in(dm),
        .data_strobe_in(dqs_bus), .data_strobe_out(dqs_r), .data_strobe_oe_out(dqs_oe),
        .bank_open_out(bank_open), .power_down_out(pd), .refresh_busy_out(ref_busy), .write_overrun_out(ovr));
    dmap_ctrl_model mdl (.clk_sys_in(clk_sys_in), .ck_t_out(ck_t), .ck_c_out(ck_c), .gate_out(gate),
        .sel_n_out(sel_n), .cmd_n_out(cmd_n), .bank_out(ba), .addr_out(addr), .dq_out(dq_w), .dm_out(dm),
        .dqs_out(dqs_w), .dq_in(dq_bus), .dq_oe_in(dq_oe), .dqs_in(dqs_bus));
    // Clock and hang limit
    always #4 clk_sys_in = ~clk_sys_in;
    always @(posedge clk_sys_in) begin
        cycles <= cycles + 1;
        if (ovr === 1'b1) chk(64'(ovr), 64'h0);
        if (cycles == 30000) begin
            mismatches++;
            wrap_up();
        end
    end
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : wrap_up
    // Masked bytes keep the first write
    function automatic logic [63:0] merge(logic [63:0] a, logic [63:0] c, logic [7:0] mk);
        for (int x = 0; x < 8; x++) if (!mk[x]) a[x*8 +: 8] = c[x*8 +: 8];
        return a;
    endfunction : merge
    // Main sequence: every length and order, random start column
    initial begin
        logic [63:0] d[8], e[8];
        logic [7:0]  m[8], z[8];
        logic [1:0]  b;
        int          len, st, j;
        logic        il;
        void'($urandom(32'h5088));
        repeat (12) @(posedge clk_sys_in);
        nrst_in <= 1'b1;
        repeat (4) @(posedge clk_sys_in);
        for (int k = 0; k < 6; k++) begin
            len = 2 << (k % 3);
            il = (k >= 3);
            st = $urandom_range(len - 1);
            b = 2'($urandom);
            foreach (d[i]) begin
                d[i] = {$urandom, $urandom};
                e[i] = {$urandom, $urandom};
                m[i] = 8'($urandom);
                z[i] = 8'h00;
            end
            mdl.cmd(1, DMAP_CMD_LMR, 2'h0, {9'h0, il, 3'(k % 3 + 1)});
            mdl.cmd(1, DMAP_CMD_LMR, 2'h1, 13'h1);
            mdl.cmd(1, DMAP_CMD_ACT, b, 13'($urandom));
            chk(64'(bank_open[b]), 64'h1);
            mdl.cmd(0, DMAP_CMD_PRE, b, 13'h400);
            chk(64'(bank_open[b]), 64'h1);
            mdl.cmd(1, DMAP_CMD_WR, b, 13'h0);
            mdl.wr(d, z, len);
            mdl.cmd(1, DMAP_CMD_WR, b, 13'h0);
            mdl.wr(e, m, len);
            repeat (4) @(negedge ck_t);
            mdl.rd_q.delete();
            mdl.cmd(1, DMAP_CMD_RD, b, 13'h400 | 13'(st));
            repeat (len / 2 + 4) @(posedge ck_t);
            chk(64'(mdl.rd_q.size()), 64'(len));
            for (int i = 0; i < len; i++) begin
                j = il ? ((st ^ i) & (len - 1)) : ((st + i) & (len - 1));
                chk(mdl.rd_q[i], merge(d[j], e[j], m[j]));
            end
            chk(64'(bank_open[b]), 64'h0);
        end
        // Two banks open, precharge one, then precharge all
        mdl.cmd(1, DMAP_CMD_ACT, 2'h0, 13'h5);
        mdl.cmd(1, DMAP_CMD_ACT, 2'h3, 13'h9);
        chk(64'(bank_open), 64'h9);
        mdl.cmd(1, DMAP_CMD_PRE, 2'h3, 13'h0);
        chk(64'(bank_open), 64'h1);
        mdl.cmd(1, DMAP_CMD_PRE, 2'h1, 13'h400);
        chk(64'(bank_open), 64'h0);
        mdl.cmd(1, DMAP_CMD_REF, 2'h0, 13'h0);
        chk(64'(ref_busy), 64'h1);
        mdl.gate_out <= 1'b0;
        repeat (2) @(posedge ck_t);
        mdl.cmd(1, DMAP_CMD_ACT, 2'h2, 13'h1);
        chk(64'({pd, bank_open}), 64'h10);
        mdl.gate_out <= 1'b1;
        repeat (2) @(negedge ck_t);
        chk(64'(pd), 64'h0);
        wrap_up();
    end
endmodule : tb_top
